//--- rtl/seit_pkg.sv
/*
  Shared constants and types for the two-wire serial memory target.
  Assumes a single 125 MHz reference clock domain for all users.
*/
`default_nettype none
package seit_pkg;
  // array and page geometry, select strap width
  localparam int MEM_AW = 16;
  localparam int MEM_DEPTH = 65536;
  localparam int PAGE_BYTES = 128;
  localparam int PAGE_AW = 7;
  localparam int STRAP_W = 3;
  // target address type code, arbitrary value
  localparam logic [3:0] DEV_TYPE_DEF = 4'ha;
  // programming path
  localparam int FIFO_W = 24;
  localparam int FIFO_DEPTH = 16;
  localparam int PROG_DIV = 8;
  // reset values
  localparam logic [15:0] COUNTER_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // bit counts within one byte frame
  localparam logic [3:0] BITS_RX = 4'h8;
  localparam logic [3:0] BITS_TX_LAST = 4'h7;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_MACK = 5'h10
  } seit_state_t;

  typedef enum logic [3:0] {
    K_DEV = 4'h1,
    K_ADDRH = 4'h2,
    K_ADDRL = 4'h4,
    K_DATA = 4'h8
  } seit_kind_t;
endpackage : seit_pkg
`default_nettype wire

//--- rtl/seit_fifo.sv
/*
  Parameterised valid/ready FIFO that carries address/data words to the array.
  Assumes one clock, asynchronous active-high reset, DEPTH of two or more.
*/
`default_nettype none
module seit_fifo
  import seit_pkg::*;
#(
  parameter int WIDTH = FIFO_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
  logic [AW:0] count_reg, count_next;
  logic push, pop;

  // honest flags straight from the occupancy count
  assign inReady = (count_reg != FULL);
  assign outValid = (count_reg != '0);
  assign outData = store[rdPtr_reg];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  // pointer wrap handles depths that are not a power of two
  always_comb
  begin
    wrPtr_next = wrPtr_reg;
    rdPtr_next = rdPtr_reg;
    count_next = count_reg;
    if (push)
      wrPtr_next = (wrPtr_reg == LAST) ? '0 : wrPtr_reg + 1'b1;
    if (pop)
      rdPtr_next = (rdPtr_reg == LAST) ? '0 : rdPtr_reg + 1'b1;
    if (push && !pop)
      count_next = count_reg + 1'b1;
    else if (pop && !push)
      count_next = count_reg - 1'b1;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
    end
  end

  // storage carries no reset, only the pointers and the count do
  always_ff @(posedge ref_clk)
  begin
    if (push)
      store[wrPtr_reg] <= inData;
  end
endmodule // seit_fifo
`default_nettype wire

//--- rtl/seit_target.sv
/*
  Two-wire bus target of a 64K x 8 serial memory: condition decode, address
  match, byte/page write with internal write cycle, immediate/selective/
  sequential read. Assumes the bus pins are asynchronous to ref_clk and that
  ref_clk is many times faster than the serial clock.
*/
// Functional notes
// - byte-wide array of 65536 locations, 16-bit address
// - write data held in 128-byte page buffer
// - write-protect high refuses every write
// - answer only when select bits match straps
// - reset lands in standby, reasserting resets again
// - sample on rise, change on fall, open drain
// - zero pulls line low, one releases it
// - data change while clock high is START/STOP
// - four bytes acknowledged, STOP launches internal write
// - no acknowledge during internal write cycle
// - counter holds next location, wraps to zero on reads, to the page start on writes
// - read address acknowledged, then current byte shifted
// - dummy write loads counter, repeated START reads
// - controller ack advances counter, keeps sending
// - sequential read wraps past last location
`default_nettype none
module seit_target
  import seit_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE = DEV_TYPE_DEF,
  parameter int PROG_CYC = PROG_DIV
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclPin,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  input wire logic writeProtect,
  output logic writeBusy
);
  localparam int SYNC_W = 6;
  // bus lines idle high, straps and write-protect idle low behind their pull-downs
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 6'h03;

  logic [SYNC_W-1:0] syncRaw, syncA_reg, syncB_reg;
  logic sclS, sdaS, wpS;
  logic [STRAP_W-1:0] strapS;
  logic sclD_reg, sdaD_reg;
  logic sclRise, sclFall, startDet, stopDet;

  seit_state_t state_reg, state_next;
  seit_kind_t kind_reg, kind_next;
  logic [3:0] bitCnt_reg, bitCnt_next;
  logic [7:0] shift_reg, shift_next, tx_reg, tx_next;
  logic [7:0] addrHi_reg, addrHi_next, pageCnt_reg, pageCnt_next;
  logic [7:0] pushIdx_reg, pushIdx_next, divCnt_reg, divCnt_next;
  logic [MEM_AW-1:0] counter_reg, counter_next;
  logic [PAGE_AW-1:0] baseLow_reg, baseLow_next, pushLow;
  logic rw_reg, rw_next, mAck_reg, mAck_next, commit_reg, commit_next;
  logic sdaOe_reg, sdaOe_next, busy_reg, busy_next;
  logic pbWe, ackIt, progTick, busyNow;
  logic [7:0] memRd;

  logic [7:0] mem [MEM_DEPTH];
  logic [7:0] pageBuf [PAGE_BYTES];

  logic fifoInReady, fifoOutValid;
  logic [FIFO_W-1:0] fifoInData, fifoOutData;

  // pins and straps are asynchronous, two flops each before any use
  assign syncRaw = {writeProtect, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0,
                    sdaIn, sclPin};
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++)
    begin : g_sync
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          syncA_reg[gi] <= SYNC_IDLE[gi];
          syncB_reg[gi] <= SYNC_IDLE[gi];
        end
        else
        begin
          syncA_reg[gi] <= syncRaw[gi];
          syncB_reg[gi] <= syncA_reg[gi];
        end
      end
    end
  endgenerate

  assign sclS = syncB_reg[0];
  assign sdaS = syncB_reg[1];
  assign strapS = syncB_reg[4:2];
  assign wpS = syncB_reg[5];

  // edges of the sampled clock and bus conditions
  assign sclRise = sclS & ~sclD_reg;
  assign sclFall = ~sclS & sclD_reg;
  assign startDet = sclS & sclD_reg & sdaD_reg & ~sdaS;
  assign stopDet = sclS & sclD_reg & ~sdaD_reg & sdaS;

  assign memRd = mem[counter_reg];
  assign busyNow = commit_reg | fifoOutValid;
  assign pushLow = baseLow_reg + pushIdx_reg[PAGE_AW-1:0];
  assign progTick = (divCnt_reg == 8'(PROG_CYC - 1));
  assign fifoInData = {counter_reg[MEM_AW-1:PAGE_AW], pushLow, pageBuf[pushLow]};

  // bus protocol engine and write-cycle launcher
  always_comb
  begin
    state_next = state_reg;
    kind_next = kind_reg;
    bitCnt_next = bitCnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    addrHi_next = addrHi_reg;
    pageCnt_next = pageCnt_reg;
    pushIdx_next = pushIdx_reg;
    counter_next = counter_reg;
    baseLow_next = baseLow_reg;
    rw_next = rw_reg;
    mAck_next = mAck_reg;
    commit_next = commit_reg;
    sdaOe_next = sdaOe_reg;
    pbWe = 1'b0;
    ackIt = 1'b0;
    divCnt_next = progTick ? 8'h00 : divCnt_reg + 8'h01;
    // page buffer drains into the FIFO one entry per accepted push
    if (commit_reg && fifoInReady)
    begin
      pushIdx_next = pushIdx_reg + 8'h01;
      if (pushIdx_next == pageCnt_reg)
      begin
        commit_next = 1'b0;
        pageCnt_next = BYTE_RST;
      end
    end
    if (startDet)
    begin
      state_next = ST_RX;
      kind_next = K_DEV;
      bitCnt_next = 4'h0;
      sdaOe_next = 1'b0;
    end
    else if (stopDet)
    begin
      state_next = ST_IDLE;
      sdaOe_next = 1'b0;
      if (pageCnt_reg != BYTE_RST && !wpS && !commit_reg)
      begin
        commit_next = 1'b1;
        pushIdx_next = BYTE_RST;
        // restart the pacing so every write cycle lasts at least one full tick period
        divCnt_next = BYTE_RST;
      end
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          sdaOe_next = 1'b0;
        end
        ST_RX:
        begin
          if (sclRise && bitCnt_reg != BITS_RX)
          begin
            shift_next = {shift_reg[6:0], sdaS};
            bitCnt_next = bitCnt_reg + 4'h1;
          end
          else if (sclFall && bitCnt_reg == BITS_RX)
          begin
            case (kind_reg)
              K_DEV:
              begin
                // type code, selects, read/write in bit 0
                ackIt = (shift_reg[7:4] == DEV_TYPE) && (shift_reg[3:1] == strapS)
                        && !busyNow;
                rw_next = shift_reg[0];
              end
              K_ADDRH:
              begin
                addrHi_next = shift_reg;
                ackIt = 1'b1;
              end
              K_ADDRL:
              begin
                counter_next = {addrHi_reg, shift_reg};
                baseLow_next = shift_reg[PAGE_AW-1:0];
                pageCnt_next = BYTE_RST;
                ackIt = 1'b1;
              end
              K_DATA:
              begin
                // protected writes are refused with no-ack
                if (!wpS)
                begin
                  pbWe = 1'b1;
                  counter_next = {counter_reg[MEM_AW-1:PAGE_AW],
                                  counter_reg[PAGE_AW-1:0] + 7'h01};
                  if (pageCnt_reg != 8'(PAGE_BYTES))
                    pageCnt_next = pageCnt_reg + 8'h01;
                  ackIt = 1'b1;
                end
              end
              default:
              begin
                ackIt = 1'b0;
              end
            endcase
            state_next = ackIt ? ST_ACK : ST_IDLE;
            sdaOe_next = ackIt;
          end
        end
        ST_ACK:
        begin
          if (sclFall)
          begin
            sdaOe_next = 1'b0;
            bitCnt_next = 4'h0;
            if (kind_reg == K_DEV && rw_reg)
            begin
              tx_next = memRd;
              sdaOe_next = ~memRd[7];
              counter_next = counter_reg + 16'h0001;
              state_next = ST_TX;
            end
            else
            begin
              state_next = ST_RX;
              case (kind_reg)
                K_DEV: kind_next = K_ADDRH;
                K_ADDRH: kind_next = K_ADDRL;
                default: kind_next = K_DATA;
              endcase
            end
          end
        end
        ST_TX:
        begin
          if (sclFall)
          begin
            if (bitCnt_reg == BITS_TX_LAST)
            begin
              sdaOe_next = 1'b0;
              mAck_next = 1'b0;
              state_next = ST_MACK;
            end
            else
            begin
              tx_next = {tx_reg[6:0], 1'b0};
              sdaOe_next = ~tx_reg[6];
              bitCnt_next = bitCnt_reg + 4'h1;
            end
          end
        end
        ST_MACK:
        begin
          if (sclRise)
          begin
            if (sdaS)
              state_next = ST_IDLE;
            else
              mAck_next = 1'b1;
          end
          else if (sclFall && mAck_reg)
          begin
            tx_next = memRd;
            sdaOe_next = ~memRd[7];
            counter_next = counter_reg + 16'h0001;
            bitCnt_next = 4'h0;
            state_next = ST_TX;
          end
        end
        default:
        begin
          state_next = ST_IDLE;
          sdaOe_next = 1'b0;
        end
      endcase
    end
    // busyNow bridges the cycle in which the last entry moves into the FIFO
    busy_next = commit_next | busyNow;
  end

  // reset puts the engine in standby with the line released
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      kind_reg <= K_DEV;
      bitCnt_reg <= 4'h0;
      shift_reg <= BYTE_RST;
      tx_reg <= BYTE_RST;
      addrHi_reg <= BYTE_RST;
      pageCnt_reg <= BYTE_RST;
      pushIdx_reg <= BYTE_RST;
      divCnt_reg <= BYTE_RST;
      counter_reg <= COUNTER_RST;
      baseLow_reg <= '0;
      rw_reg <= 1'b0;
      mAck_reg <= 1'b0;
      commit_reg <= 1'b0;
      sdaOe_reg <= 1'b0;
      busy_reg <= 1'b0;
      sclD_reg <= 1'b1; // idle level, so no false edge follows reset
      sdaD_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      bitCnt_reg <= bitCnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      addrHi_reg <= addrHi_next;
      pageCnt_reg <= pageCnt_next;
      pushIdx_reg <= pushIdx_next;
      divCnt_reg <= divCnt_next;
      counter_reg <= counter_next;
      baseLow_reg <= baseLow_next;
      rw_reg <= rw_next;
      mAck_reg <= mAck_next;
      commit_reg <= commit_next;
      sdaOe_reg <= sdaOe_next;
      busy_reg <= busy_next;
      sclD_reg <= sclS;
      sdaD_reg <= sdaS;
    end
  end

  // array and page buffer hold no reset; contents survive a bus reset
  always_ff @(posedge ref_clk)
  begin
    if (pbWe)
      pageBuf[counter_reg[PAGE_AW-1:0]] <= shift_reg;
    if (fifoOutValid && progTick)
      mem[fifoOutData[FIFO_W-1:8]] <= fifoOutData[7:0];
  end

  // the slow programming tick stalls the drain, so the FIFO really fills
  seit_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_prog_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .inValid(commit_reg),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(progTick),
    .outData(fifoOutData)
  );

  // open drain: only ever pull low, the clock is never driven
  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_reg;
  assign writeBusy = busy_reg;

  logic devDecide;
  assign devDecide = (state_reg == ST_RX) && sclFall && (bitCnt_reg == BITS_RX) &&
                     (kind_reg == K_DEV) && !startDet && !stopDet;

  wp_refuse_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == ST_RX) && sclFall && bitCnt_reg == BITS_RX && kind_reg == K_DATA
    && wpS && !startDet && !stopDet |=> !sdaOe && !pbWe ##0 state_reg == ST_IDLE)
    else $error("protected data byte was acknowledged");
  strap_mismatch_a: assert property (@(posedge ref_clk) disable iff (rst)
    devDecide && shift_reg[3:1] != strapS |=> !sdaOe [*2])
    else $error("acknowledged a foreign select code");
  type_mismatch_a: assert property (@(posedge ref_clk) disable iff (rst)
    devDecide && shift_reg[7:4] != DEV_TYPE |=> state_reg == ST_IDLE && !sdaOe)
    else $error("acknowledged a foreign type code");
  busy_nack_a: assert property (@(posedge ref_clk) disable iff (rst)
    devDecide && busyNow |=> !sdaOe)
    else $error("acknowledged during internal write");
  addr_ack_a: assert property (@(posedge ref_clk) disable iff (rst)
    devDecide && shift_reg[7:1] == {DEV_TYPE, strapS} && !busyNow |=> sdaOe)
    else $error("matching address not acknowledged");
  oe_on_fall_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(sdaOe_reg) |-> $past(sclFall))
    else $error("line pulled low outside a falling clock edge");
  write_launch_a: assert property (@(posedge ref_clk) disable iff (rst)
    stopDet && pageCnt_reg != BYTE_RST && !wpS && !commit_reg |=> commit_reg ##1 writeBusy)
    else $error("stop did not launch the internal write");
  read_wrap_a: assert property (@(posedge ref_clk) disable iff (rst)
    state_next == ST_TX && state_reg != ST_TX && counter_reg == 16'hffff
    |=> counter_reg == COUNTER_RST)
    else $error("address counter did not wrap");
  page_limit_a: assert property (@(posedge ref_clk) disable iff (rst)
    pageCnt_reg <= 8'(PAGE_BYTES))
    else $error("page buffer count beyond its size");
  no_ack_end_a: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == ST_MACK && sclRise && sdaS && !startDet && !stopDet
    |=> state_reg == ST_IDLE ##1 !sdaOe)
    else $error("kept sending after no-ack");

  commit_c: cover property (@(posedge ref_clk) disable iff (rst)
    $fell(writeBusy));
  seq_read_c: cover property (@(posedge ref_clk) disable iff (rst)
    state_reg == ST_MACK && state_next == ST_TX);
  foreign_c: cover property (@(posedge ref_clk) disable iff (rst)
    devDecide && shift_reg[3:1] != strapS);
endmodule // seit_target
`default_nettype wire

//--- testbench/seit_bus_ctrl.sv
/*
  Behavioural two-wire bus controller that drives the serial clock and data line.
  Assumes the bench resolves the data line from all open-drain pulls plus a pull-up.
*/
`default_nettype none
module seit_bus_ctrl (
  output logic scl,
  output logic sdaLow,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 10ps;

  // quarter of the 125 ns link period; data moves a quarter after a fall so the
  // synchronised view never sees data change while the clock is still high
  localparam real QTR = 31.25;

  // idle bus: clock high, data released to the pull-up
  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  // start or repeated start; data is released and the clock raised first, so read_bytes also calls it mid-frame
  task automatic bus_start();
    sdaLow = 1'b0;
    #(QTR);
    scl = 1'b1;
    #(QTR);
    sdaLow = 1'b1;
    #(QTR);
    scl = 1'b0;
    #(QTR);
  endtask

  // stop: data rises while the clock is high
  task automatic bus_stop();
    sdaLow = 1'b1;
    #(QTR);
    scl = 1'b1;
    #(QTR);
    sdaLow = 1'b0;
    #(QTR);
    #(QTR);
  endtask

  // one clock: data set while low, held through high, sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    sdaLow = ~b;
    #(QTR);
    scl = 1'b1;
    #(QTR);
    s = sda;
    #(QTR);
    scl = 1'b0;
    #(QTR);
  endtask

  // eight data bits then the ninth clock for the target's answer
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // a no-ack on the last byte ends a read before the stop
  task automatic recv_byte(input logic ackIt, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(~ackIt, s);
  endtask
endmodule // seit_bus_ctrl
`default_nettype wire

//--- testbench/serial_eeprom_i2c_target_tb_top.sv
/*
  Self-checking bench for the two-wire serial memory target.
  Assumes the bus controller model and a wired-AND data line with pull-up.
*/
`default_nettype none
module serial_eeprom_i2c_target_tb_top;
  import seit_pkg::*;
  timeunit 1ns;
  timeprecision 10ps;

  logic ref_clk;
  logic rst;
  logic writeProtect;
  logic [2:0] strapSel;
  logic ctrlScl;
  logic ctrlLow;
  logic sdaLine;
  logic sdaOut;
  logic sdaOe;
  logic writeBusy;
  int failCount;
  int compares;

  // open-drain resolution: anyone pulling wins, otherwise the pull-up
  assign sdaLine = ~(ctrlLow | (sdaOe & ~sdaOut));

  // long write cycle so a poll can land inside it
  seit_target #(.PROG_CYC(255)) u_dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .sclPin(ctrlScl),
    .sdaIn(sdaLine),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .addr_strap_bit0(strapSel[0]),
    .addr_strap_bit1(strapSel[1]),
    .addr_strap_bit2(strapSel[2]),
    .writeProtect(writeProtect),
    .writeBusy(writeBusy)
  );

  seit_bus_ctrl u_ctrl (
    .scl(ctrlScl),
    .sdaLow(ctrlLow),
    .sda(sdaLine)
  );

  // 125 MHz reference clock
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failCount++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic tallyAndFinish();
    $display("compares=%0d mismatches=%0d", compares, failCount);
    if (failCount == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic logic [7:0] dev_byte(input logic rw);
    return {DEV_TYPE_DEF, strapSel, rw};
  endfunction

  // reset for two cycles, then leave the synchronisers time to settle
  task automatic do_reset();
    @(posedge ref_clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 check(sdaOe, 1'b0);
    check(writeBusy, 1'b0);
    rst = 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask

  // byte write; while busy an address poll must go unanswered
  task automatic write_byte(input logic [15:0] a, input logic [7:0] d, input logic dataAck);
    logic ack;
    int n;
    u_ctrl.bus_start();
    u_ctrl.send_byte(dev_byte(1'b0), ack);
    check(ack, 1'b1);
    u_ctrl.send_byte(a[15:8], ack);
    check(ack, 1'b1);
    u_ctrl.send_byte(a[7:0], ack);
    check(ack, 1'b1);
    u_ctrl.send_byte(d, ack);
    check(ack, dataAck);
    u_ctrl.bus_stop();
    n = 0;
    while (writeBusy !== 1'b1 && n < 20)
    begin
      @(negedge ref_clk); // sample the flag where it has settled
      n++;
    end
    check(writeBusy, dataAck);
    if (dataAck)
    begin
      u_ctrl.bus_start();
      u_ctrl.send_byte(dev_byte(1'b1), ack);
      u_ctrl.bus_stop();
      check(ack, 1'b0);
      n = 0;
      while (writeBusy !== 1'b0 && n < 1000)
      begin
        @(negedge ref_clk);
        n++;
      end
      check(writeBusy, 1'b0);
    end
  endtask

  // selective or immediate read of one or two bytes
  task automatic read_bytes(input logic sel, input logic [15:0] a, input logic [7:0] e0,
                            input logic [7:0] e1, input int cnt);
    logic ack;
    logic [7:0] d;
    u_ctrl.bus_start();
    if (sel)
    begin
      u_ctrl.send_byte(dev_byte(1'b0), ack);
      u_ctrl.send_byte(a[15:8], ack);
      u_ctrl.send_byte(a[7:0], ack);
      check(ack, 1'b1);
      u_ctrl.bus_start();
    end
    u_ctrl.send_byte(dev_byte(1'b1), ack);
    check(ack, 1'b1);
    u_ctrl.recv_byte(cnt > 1, d);
    check(d, e0);
    if (cnt > 1)
    begin
      u_ctrl.recv_byte(1'b0, d);
      check(d, e1);
    end
    u_ctrl.bus_stop();
    check(sdaOe, 1'b0);
  endtask

  // every other select value and a wrong type code must stay unanswered
  task automatic test_mismatch();
    logic ack;
    for (int n = 0; n < 9; n++)
    begin
      if (n[2:0] == strapSel && n < 8)
        continue;
      u_ctrl.bus_start();
      if (n < 8)
        u_ctrl.send_byte({DEV_TYPE_DEF, n[2:0], 1'b1}, ack);
      else
        u_ctrl.send_byte({~DEV_TYPE_DEF, strapSel, 1'b1}, ack);
      u_ctrl.bus_stop();
      check(ack, 1'b0);
    end
  endtask

  // main sequence
  initial
  begin
    rst = 1'b1;
    writeProtect = 1'b0;
    strapSel = 3'h0;
    failCount = 0;
    compares = 0;
    do_reset();
    write_byte(16'h1234, 8'h5a, 1'b1);
    write_byte(16'h1235, 8'hc3, 1'b1);
    read_bytes(1'b1, 16'h1234, 8'h5a, 8'hc3, 2);
    read_bytes(1'b1, 16'h1234, 8'h5a, 8'h00, 1);
    read_bytes(1'b0, 16'h0000, 8'hc3, 8'h00, 1);
    write_byte(16'hffff, 8'h81, 1'b1);
    write_byte(16'h0000, 8'h7e, 1'b1);
    read_bytes(1'b1, 16'hffff, 8'h81, 8'h7e, 2);
    @(posedge ref_clk);
    #1 writeProtect = 1'b1;
    write_byte(16'h1234, 8'hee, 1'b0);
    @(posedge ref_clk);
    #1 writeProtect = 1'b0;
    read_bytes(1'b1, 16'h1234, 8'h5a, 8'h00, 1);
    test_mismatch();
    @(posedge ref_clk);
    #1 strapSel = 3'h5;
    test_mismatch();
    write_byte(16'h0100, 8'h3c, 1'b1);
    read_bytes(1'b1, 16'h0100, 8'h3c, 8'h00, 1);
    do_reset();
    read_bytes(1'b0, 16'h0000, 8'h7e, 8'h00, 1);
    tallyAndFinish();
  end

  // watchdog: the sequence needs roughly 100 us of bus time
  initial
  begin
    #400us;
    failCount++;
    tallyAndFinish();
  end
endmodule // serial_eeprom_i2c_target_tb_top
`default_nettype wire
